/* File: core/pulse_status_pkg.sv */
/*
 * Package for the pulse measurement status encoder: register map, status
 * digit codes, field layouts and the carrier structs of the measurement path.
 * Assumes a 32-bit AXI4-Lite register bus and a 200 MHz system clock.
 */
package pulse_status_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_RANGE = 8'h04;
	localparam logic [7:0] OFF_ITHR0 = 8'h08;
	localparam logic [7:0] OFF_ITHR1 = 8'h0c;
	localparam logic [7:0] OFF_VTHR0 = 8'h10;
	localparam logic [7:0] OFF_VTHR1 = 8'h14;
	localparam logic [7:0] OFF_PTHR0 = 8'h18;
	localparam logic [7:0] OFF_PTHR1 = 8'h1c;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
	localparam logic [7:0] OFF_THR_EN = 8'h2c;

	// control register bits
	localparam int CTRL_SHORT_COMP = 0;
	localparam int CTRL_LOAD_COMP = 1;
	localparam int CTRL_WAVEFORM = 2;
	localparam int CTRL_CHANNEL = 3;
	localparam int CTRL_RANGE40 = 4;
	localparam int CTRL_ROUTE_LSB = 8;
	localparam int ROUTE_W = 3;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// digit A
	localparam logic [3:0] COMP_OFF = 4'h0;
	localparam logic [3:0] COMP_FAIL = 4'h1;
	localparam logic [3:0] COMP_OK = 4'h3;
	localparam logic [3:0] SKIP_ADD = 4'h4;
	// digit B
	localparam logic [2:0] ROUTE_NONE = 3'h0;
	localparam logic [2:0] ROUTE_PREAMP = 3'h1;
	localparam logic [2:0] ROUTE_BYPASS_MAX = 3'h4;
	// digit C, D
	localparam logic [3:0] DIGIT_RESERVED = 4'h0;
	localparam logic [3:0] TYPE_SPOT = 4'h1;
	localparam logic [3:0] TYPE_WAVE = 4'h2;
	// digit E weights
	localparam int LIM_COMPLIANCE = 0;
	localparam int LIM_CURRENT = 1;
	localparam int LIM_VOLTAGE = 2;
	localparam int LIM_POWER = 3;
	// digit F weights
	localparam int OVF_NEG_V = 0;
	localparam int OVF_POS_V = 1;
	localparam int OVF_NEG_I = 2;
	localparam int OVF_POS_I = 3;
	// digit G: ranges usable without the preamplifier
	localparam logic [7:0] RANGE_DIRECT_OK = 8'b1110_1000;
	// digit H
	localparam logic [3:0] CH1_10V = 4'h1;
	localparam logic [3:0] RANGE40_ADD = 4'h4;

	// status word nibble positions, digit A first
	localparam int DIG_A = 28;
	localparam int DIG_B = 24;
	localparam int DIG_C = 20;
	localparam int DIG_D = 16;
	localparam int DIG_E = 12;
	localparam int DIG_F = 8;
	localparam int DIG_G = 4;
	localparam int DIG_H = 0;

	// interrupt status bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_THRESH = 1;
	localparam int IRQ_FAULT = 2;
	localparam int IRQ_W = 3;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// one measurement from the acquisition path
	typedef struct packed {
		logic valid;
		logic sweepStart;
		logic signed [31:0] current;
		logic signed [31:0] voltage;
		logic compliance;
		logic [3:0] overflow;
		logic [2:0] iRange;
		logic compDone;
		logic compMet;
	} meas_t;

	typedef struct packed {
		logic valid;
		logic [31:0] word;
		logic sweepStop;
	} result_t;
endpackage : pulse_status_pkg

/* File: core/pulse_measure_status_encoder.sv */
/*
 * Pulse measurement status encoder: threshold monitor with sweep stop and
 * eight-digit status word, registers over AXI4-Lite.
 * Assumes measurement path and bus master run on sys_clk; measurement
 * results arrive one cycle wide from same-clock logic.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - every measurement gets an eight-digit status word, digits A to H.
// - digit A: compensation off 0, failed 1, met 3, plus 4 if skipped.
// - digit B: preamp routing none, used, bypass pulse, source-measure, capacitance.
// - digit C reserved, always zero.
// - digit D: 1 for spot mean, 2 for waveform.
// - digit E weighted bits: compliance, current, voltage, power thresholds.
// - digit F ORed overflow bits: -V, +V, -I, +I.
// - digit G current range 0 to 7; 0,1,2,4 only with preamplifier.
// - digit H: channel plus 4 for the 40 V range.
// - current at or over its threshold stops this sweep, later sweeps run.
// - voltage at or over its threshold stops this sweep, later sweeps run.
// - power at or over its threshold stops this sweep, later sweeps run.
// - thresholds compare the measurement taken after each pulse.
// - several thresholds per quantity, each checked on its own.
// - separate enables for short and load-line compensation.
// - output limits unchanged by load-line compensation.
// - status word also readable as one 32-bit word.
module pulse_measure_status_encoder #(
	parameter int N_THR = 2
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// measurement path
	input wire pulse_status_pkg::meas_t meas,
	output pulse_status_pkg::result_t result,
	output logic shortCompEnable,
	output logic loadLineCompEnable,
	output logic [31:0] maxVoltage,
	output logic [31:0] maxCurrent,
	output logic irq,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import pulse_status_pkg::*;

	// elaboration check: the register map holds two slots per limit kind
	if (N_THR < 1 || N_THR > 2) begin : g_thr_check
		$error("N_THR must be 1 or 2");
	end

	// threshold enable bits, power window and fold codes
	localparam int EN_I = 0;
	localparam int EN_V = 1;
	localparam int EN_P = 2;
	localparam int EN_W = 3;
	localparam int POW_LSB = 16;
	localparam int LIMIT_W = 16;
	localparam logic [3:0] ROUTE_FOLD = 4'h0;
	localparam logic [3:0] RANGE_FOLD = 4'h3;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] rangeLimit;
		logic [N_THR-1:0][31:0] iThr;
		logic [N_THR-1:0][31:0] vThr;
		logic [N_THR-1:0][31:0] pThr;
		logic [EN_W-1:0] thrEn;
		logic skipping;
		logic [IRQ_W-1:0] irqStat;
		logic [IRQ_W-1:0] irqMask;
		result_t res;
		logic awHeld;
		logic [7:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
	} state_t;

	state_t st;
	state_t next_st;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] r;
		// byte lanes without a strobe keep their old value
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// most negative code wraps; the acquisition path never reports it
	function automatic logic [31:0] magnitude(input logic signed [31:0] x);
		return x[31] ? 32'(-x) : 32'(x);
	endfunction : magnitude

	// any of a set of limits reached or passed
	function automatic logic anyHit(input logic [31:0] val,
		input logic [N_THR-1:0][31:0] lim);
		logic h;
		h = 1'b0;
		for (int i = 0; i < N_THR; i++) begin
			if (lim[i] != 32'h0000_0000 && val >= lim[i]) begin
				h = 1'b1;
			end
		end
		return h;
	endfunction : anyHit

	// compensation outcome, plus 4 while the sweep is skipped
	function automatic logic [3:0] encodeA(input logic compOn, input logic met,
		input logic skipped);
		logic [3:0] a;
		if (!compOn) begin
			a = COMP_OFF;
		end else if (met) begin
			a = COMP_OK;
		end else begin
			a = COMP_FAIL;
		end
		if (skipped) begin
			a = a | SKIP_ADD;
		end
		return a;
	endfunction : encodeA

	// routing code; codes past the capacitance bypass fold to none
	function automatic logic [3:0] encodeB(input logic [ROUTE_W-1:0] r);
		return (r > ROUTE_BYPASS_MAX) ? ROUTE_FOLD : {1'b0, r};
	endfunction : encodeB

	// ranges 0, 1, 2 and 4 exist only behind the preamplifier
	function automatic logic [3:0] encodeG(input logic [ROUTE_W-1:0] r, input logic [2:0] rng);
		logic [3:0] g;
		g = {1'b0, rng};
		if (r != ROUTE_PREAMP && !RANGE_DIRECT_OK[rng]) begin
			g = RANGE_FOLD;
		end
		return g;
	endfunction : encodeG

	// channel number, plus 4 on the 40 V range
	function automatic logic [3:0] encodeH(input logic ch2, input logic hiRange);
		logic [3:0] h;
		h = CH1_10V + {3'h0, ch2};
		if (hiRange) begin
			h = h + RANGE40_ADD;
		end
		return h;
	endfunction : encodeH

	logic [31:0] absI;
	logic [31:0] absV;
	logic [63:0] power;
	logic hitI;
	logic hitV;
	logic hitP;
	logic [3:0] digA;
	logic [3:0] digE;
	logic [3:0] digG;
	logic [3:0] digH;
	logic [2:0] route;
	logic wrFire;
	logic rdFire;
	logic [31:0] rdWord;
	logic rdHit;
	logic wrHit;
	logic skipNow;
	logic thrHit;

	assign absI = magnitude(meas.current);
	assign absV = magnitude(meas.voltage);
	// full product kept; only a 32-bit window of it meets the limit
	assign power = 64'(absI) * 64'(absV);
	assign route = st.ctrl[CTRL_ROUTE_LSB +: ROUTE_W];
	// a new sweep starts unskipped; only its own hit may skip it
	assign skipNow = st.skipping && !(meas.valid && meas.sweepStart);
	assign thrHit = hitI || hitV || hitP;

	assign hitI = st.thrEn[EN_I] && anyHit(absI, st.iThr);
	assign hitV = st.thrEn[EN_V] && anyHit(absV, st.vThr);
	// power limit, compared in bits 47 to 16 of the product
	assign hitP = st.thrEn[EN_P] && anyHit(power[POW_LSB +: 32], st.pThr);

	always_comb begin
		digA = encodeA(st.ctrl[CTRL_LOAD_COMP], meas.compDone && meas.compMet, skipNow || thrHit);
		digE = 4'h0;
		digE[LIM_COMPLIANCE] = meas.compliance;
		digE[LIM_CURRENT] = hitI;
		digE[LIM_VOLTAGE] = hitV;
		digE[LIM_POWER] = hitP;
		digG = encodeG(route, meas.iRange);
		digH = encodeH(st.ctrl[CTRL_CHANNEL], st.ctrl[CTRL_RANGE40]);
	end

	// response only once both halves are in; a pending response blocks the next write
	assign wrFire = st.awHeld && st.wHeld && !st.bValid;
	// reads answer from registered data; arready drops while rvalid stands
	assign rdFire = s_axi_arvalid && !st.rValid;

	always_comb begin
		rdHit = 1'b1;
		unique case (s_axi_araddr)
			OFF_CTRL: rdWord = st.ctrl;
			OFF_RANGE: rdWord = st.rangeLimit;
			OFF_ITHR0: rdWord = st.iThr[0];
			OFF_VTHR0: rdWord = st.vThr[0];
			OFF_PTHR0: rdWord = st.pThr[0];
			OFF_ITHR1: rdWord = st.iThr[N_THR-1];
			OFF_VTHR1: rdWord = st.vThr[N_THR-1];
			OFF_PTHR1: rdWord = st.pThr[N_THR-1];
			OFF_STATUS: rdWord = st.res.word;
			OFF_IRQ_STAT: rdWord = 32'(st.irqStat);
			OFF_IRQ_MASK: rdWord = 32'(st.irqMask);
			OFF_THR_EN: rdWord = 32'(st.thrEn);
			default: begin
				rdWord = 32'h0000_0000;
				rdHit = 1'b0;
			end
		endcase
	end

	always_comb begin
		next_st = st;
		wrHit = 1'b1;
		// write channel: address and data taken in either order
		if (s_axi_awvalid && !st.awHeld) begin
			next_st.awHeld = 1'b1;
			next_st.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.wHeld) begin
			next_st.wHeld = 1'b1;
			next_st.wData = s_axi_wdata;
			next_st.wStrb = s_axi_wstrb;
		end
		if (wrFire) begin
			next_st.awHeld = 1'b0;
			next_st.wHeld = 1'b0;
			next_st.bValid = 1'b1;
			case (st.awAddr)
				OFF_CTRL: next_st.ctrl = merge(st.ctrl, st.wData, st.wStrb);
				OFF_RANGE: next_st.rangeLimit = merge(st.rangeLimit, st.wData, st.wStrb);
				OFF_ITHR0: next_st.iThr[0] = merge(st.iThr[0], st.wData, st.wStrb);
				OFF_VTHR0: next_st.vThr[0] = merge(st.vThr[0], st.wData, st.wStrb);
				OFF_PTHR0: next_st.pThr[0] = merge(st.pThr[0], st.wData, st.wStrb);
				OFF_ITHR1: next_st.iThr[N_THR-1] = merge(st.iThr[N_THR-1], st.wData, st.wStrb);
				OFF_VTHR1: next_st.vThr[N_THR-1] = merge(st.vThr[N_THR-1], st.wData, st.wStrb);
				OFF_PTHR1: next_st.pThr[N_THR-1] = merge(st.pThr[N_THR-1], st.wData, st.wStrb);
				OFF_IRQ_MASK: next_st.irqMask = st.wStrb[0] ? st.wData[IRQ_W-1:0] : st.irqMask;
				OFF_THR_EN: next_st.thrEn = st.wStrb[0] ? st.wData[EN_W-1:0] : st.thrEn;
				OFF_STATUS, OFF_IRQ_STAT: wrHit = 1'b1;
				default: wrHit = 1'b0;
			endcase
			next_st.bResp = wrHit ? RESP_OKAY : RESP_SLVERR;
		end
		if (st.bValid && s_axi_bready) begin
			next_st.bValid = 1'b0;
		end
		if (st.rValid && s_axi_rready) begin
			next_st.rValid = 1'b0;
		end
		if (rdFire) begin
			next_st.rValid = 1'b1;
			next_st.rData = rdWord;
			next_st.rResp = rdHit ? RESP_OKAY : RESP_SLVERR;
			// read clears interrupt status
			if (s_axi_araddr == OFF_IRQ_STAT) begin
				next_st.irqStat = '0;
			end
		end

		next_st.res.valid = 1'b0;
		next_st.res.sweepStop = 1'b0;
		// new sweep ends any skip
		if (meas.valid && meas.sweepStart) begin
			next_st.skipping = 1'b0;
		end
		if (meas.valid) begin
			next_st.res.valid = 1'b1;
			next_st.res.word[DIG_A +: 4] = digA;
			// routing code, unknown codes fold to none
			next_st.res.word[DIG_B +: 4] = encodeB(route);
			next_st.res.word[DIG_C +: 4] = DIGIT_RESERVED;
			next_st.res.word[DIG_D +: 4] = st.ctrl[CTRL_WAVEFORM] ? TYPE_WAVE : TYPE_SPOT;
			next_st.res.word[DIG_E +: 4] = digE;
			next_st.res.word[DIG_F +: 4] = meas.overflow;
			next_st.res.word[DIG_G +: 4] = digG;
			next_st.res.word[DIG_H +: 4] = digH;
			if (thrHit && !skipNow) begin
				next_st.skipping = 1'b1;
				next_st.res.sweepStop = 1'b1;
			end
			// events set sticky bits; set wins over read clear
			next_st.irqStat[IRQ_DONE] = 1'b1;
			if (thrHit) begin
				next_st.irqStat[IRQ_THRESH] = 1'b1;
			end
			if (meas.compliance || meas.overflow != 4'h0) begin
				next_st.irqStat[IRQ_FAULT] = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign result = st.res;
	assign shortCompEnable = st.ctrl[CTRL_SHORT_COMP];
	assign loadLineCompEnable = st.ctrl[CTRL_LOAD_COMP];
	assign maxVoltage = 32'(st.rangeLimit[LIMIT_W-1:0]);
	assign maxCurrent = 32'(st.rangeLimit[LIMIT_W +: LIMIT_W]);
	// level output; software drops it by reading the interrupt status register
	assign irq = |(st.irqStat & st.irqMask);
	assign s_axi_awready = !st.awHeld;
	assign s_axi_wready = !st.wHeld;
	assign s_axi_bvalid = st.bValid;
	assign s_axi_bresp = st.bResp;
	assign s_axi_arready = !st.rValid;
	assign s_axi_rvalid = st.rValid;
	assign s_axi_rdata = st.rData;
	assign s_axi_rresp = st.rResp;
endmodule : pulse_measure_status_encoder

`default_nettype wire

/* File: verif/pulse_status_props.sv */
/* checker: status word layout, latency and sweep stop properties
   assumes it is bound onto the encoder top module */
`timescale 1ns/1ps
`default_nettype none
module pulse_status_props import pulse_status_pkg::*; #(
	parameter int N_THR = 2
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// measurement path
	input wire pulse_status_pkg::meas_t meas,
	input wire pulse_status_pkg::result_t result,
	input wire logic loadLineCompEnable,
	input wire logic [31:0] maxVoltage
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence s_take; meas.valid; endsequence
	sequence s_emit; result.valid; endsequence
	property p_lat; s_take |=> s_emit; endproperty
	a_lat: assert property (p_lat) else $error("result missing");
	property p_nospur; !meas.valid |=> !result.valid; endproperty
	a_nospur: assert property (p_nospur) else $error("stray result");
	property p_compa; s_emit |-> result.word[31:28] inside {0, 1, 3, 4, 5, 7}; endproperty
	a_compa: assert property (p_compa) else $error("digit A code");
	property p_resv; s_emit |-> result.word[23:20] == 4'h0; endproperty
	a_resv: assert property (p_resv) else $error("reserved digit");
	property p_type; s_emit |-> result.word[19:16] inside {4'h1, 4'h2}; endproperty
	a_type: assert property (p_type) else $error("type digit");
	property p_ovf; s_take |=> result.word[11:8] == $past(meas.overflow); endproperty
	a_ovf: assert property (p_ovf) else $error("overflow digit");
	property p_rng;
		result.valid && result.word[27:24] != 4'h1 |-> !(result.word[7:4] inside {0, 1, 2, 4});
	endproperty
	a_rng: assert property (p_rng) else $error("range digit");
	property p_chan; s_emit |-> result.word[3:0] inside {4'h1, 4'h2, 4'h5, 4'h6}; endproperty
	a_chan: assert property (p_chan) else $error("channel digit");
	property p_stop; result.sweepStop |-> s_emit ##0 result.word[30] ##0 |result.word[15:13];
	endproperty
	a_stop: assert property (p_stop) else $error("stop without skip");
	property p_max; $changed(loadLineCompEnable) |-> $stable(maxVoltage); endproperty
	a_max: assert property (p_max) else $error("limit moved");
endmodule : pulse_status_props
bind pulse_measure_status_encoder pulse_status_props #(.N_THR(N_THR)) props_i (.sys_clk(sys_clk),
	.nrst(nrst), .meas(meas), .result(result), .loadLineCompEnable(loadLineCompEnable),
	.maxVoltage(maxVoltage));
`default_nettype wire

/* File: verif/dut_load_model.sv */
/* resistive device under test behind one pulse channel
   assumes one pulse request at a time on sys_clk */
`timescale 1ns/1ps
`default_nettype none
module dut_load_model import pulse_status_pkg::*; #(
	parameter int GAIN = 3
) (
	// pulse request
	input wire logic sys_clk,
	input wire logic fire,
	input wire logic first,
	input wire logic signed [31:0] amp,
	input wire logic [9:0] aux,
	// measurement out
	output pulse_status_pkg::meas_t meas
);
	always_ff @(posedge sys_clk) begin
		meas.valid <= fire;
		if (fire) begin
			meas.sweepStart <= first;
			meas.voltage <= amp;
			meas.current <= amp * GAIN;
			{meas.compliance, meas.overflow, meas.iRange, meas.compDone, meas.compMet} <= aux;
		end else begin
			// idle lines churn so stale data never looks valid
			meas.current <= ~meas.current;
			meas.voltage <= ~meas.voltage;
		end
	end
endmodule : dut_load_model
`default_nettype wire

/* File: verif/testbench.sv */
/* testbench: register bus, threshold stop, interrupt and status word
   assumes the encoder package and the resistive load model */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pulse_status_pkg::*;
	logic sys_clk = 0, nrst = 0, fire = 0, first = 0, skip = 0;
	logic signed [31:0] amp = 0;
	logic [9:0] aux = 0;
	meas_t meas;
	result_t result;
	logic shortCompEnable, loadLineCompEnable, irq;
	logic [31:0] maxVoltage, maxCurrent, rv, ctrl, last, rng;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
	logic [2:0] en = 0;
	int miscompares = 0, samples_checked = 0, seed = 76645;
	initial forever #2.5 sys_clk = ~sys_clk;
	pulse_measure_status_encoder #(.N_THR(2)) pulse_measure_status_encoder_i (.sys_clk, .nrst,
		.meas, .result, .shortCompEnable, .loadLineCompEnable, .maxVoltage, .maxCurrent, .irq,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	dut_load_model dut_load_model_i (.sys_clk, .fire, .first, .amp, .aux, .meas);
	task automatic chk(input logic ok, input string m);
		samples_checked++;
		if (!ok) begin
			miscompares++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		br = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	function automatic logic [31:0] expw(logic [31:0] c, logic [9:0] x, logic [3:0] e, logic sk);
		logic [3:0] a, b, g;
		a = !c[1] ? 4'h0 : (x[1] && x[0]) ? 4'h3 : 4'h1;
		b = (c[10:8] > 3'h4) ? 4'h0 : {1'b0, c[10:8]};
		g = {1'b0, x[4:2]};
		if (b != 4'h1 && g inside {4'h0, 4'h1, 4'h2, 4'h4}) g = 4'h3;
		return {a | (sk ? 4'h4 : 4'h0), b, 4'h0, c[2] ? 4'h2 : 4'h1, e | {3'h0, x[9]}, x[8:5], g,
			4'h1 + {3'h0, c[3]} + (c[4] ? 4'h4 : 4'h0)};
	endfunction : expw
	function automatic logic [3:0] hits(logic signed [31:0] v, logic [2:0] n);
		longint av, ai;
		av = v < 0 ? -v : v;
		ai = 3 * av;
		return {n[2] && ((ai * av) >> 16) >= 40, n[1] && av >= 1500, n[0] && ai >= 6000, 1'b0};
	endfunction : hits
	task automatic shot(input logic f, input logic signed [31:0] v, input logic [9:0] x);
		logic [3:0] e;
		logic stop;
		e = hits(v, en);
		stop = (e != 4'h0) && !(skip && !f);
		skip = (e != 4'h0) || (skip && !f);
		last = expw(ctrl, x, e, skip);
		@(posedge sys_clk);
		fire <= 1'b1;
		first <= f;
		amp <= v;
		aux <= x;
		@(posedge sys_clk);
		fire <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk(result.valid === 1'b1 && result.word === last, "status word");
		chk(result.sweepStop === stop, "sweep stop");
	endtask : shot
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : close_out
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		close_out;
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(OFF_CTRL);
		chk(rv === CTRL_RESET && rr === RESP_OKAY, "ctrl reset");
		rd(8'h40);
		chk(rv === 32'h0 && rr === RESP_SLVERR, "unmapped read");
		wr(8'h40, 32'h1);
		chk(br === RESP_SLVERR, "unmapped write");
		wr(OFF_ITHR1, 32'd6000);
		wr(OFF_VTHR0, 32'd1500);
		wr(OFF_PTHR0, 32'd40);
		chk(br === RESP_OKAY, "write resp");
		for (int i = 0; i < 6; i++) begin
			ctrl = $random(seed) & 32'h1f;
			ctrl[10:8] = 3'($random(seed));
			en = 3'($random(seed));
			rng = $random(seed);
			wr(OFF_RANGE, rng);
			wr(OFF_CTRL, ctrl);
			wr(OFF_THR_EN, {29'h0, en});
			chk(shortCompEnable === ctrl[0] && loadLineCompEnable === ctrl[1], "enables");
			chk(maxVoltage === {16'h0, rng[15:0]} && maxCurrent === {16'h0, rng[31:16]}, "max");
			for (int k = 0; k < 10; k++)
				shot(k % 4 == 0, k == 1 ? 32'sd1500 : 32'($random(seed) % 2048), 10'($random(seed)));
		end
		wr(OFF_STATUS, 32'hffff_ffff);
		chk(br === RESP_OKAY, "status write");
		rd(OFF_STATUS);
		chk(rv === last, "status readback");
		wr(OFF_IRQ_MASK, 32'h2);
		en = 3'h2;
		wr(OFF_THR_EN, 32'h2);
		rd(OFF_IRQ_STAT);
		shot(1'b1, 32'sd1600, 10'h0);
		rd(OFF_CTRL);
		chk(irq === 1'b1, "irq raised");
		rd(OFF_IRQ_STAT);
		chk(rv === 32'h3, "irq status");
		rd(OFF_CTRL);
		chk(irq === 1'b0, "irq cleared");
		wr(OFF_IRQ_MASK, 32'h0);
		shot(1'b1, -32'sd1700, 10'h0);
		rd(OFF_CTRL);
		chk(irq === 1'b0, "irq masked");
		close_out;
	end
endmodule : testbench
`default_nettype wire
